// file: hw/rx_latch_pkg.sv
/*
 * Constants and carrier types for the receive status latch and interrupt
 * enable block of an E3 G.832 framer port.
 * Assumes one 100 MHz system clock and APB word addressing (index * 4).
 */
package rx_latch_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ALARM_LATCH = 10'h128;
	localparam logic [9:0] IDX_ERR_LATCH = 10'h12A;
	localparam logic [9:0] IDX_ALARM_IE = 10'h12C;
	localparam logic [9:0] IDX_ERR_IE = 10'h12E;
	localparam logic [9:0] IDX_MAINT = 10'h130;
	localparam int ADDR_W = 12;

	// Implemented bits per register, all else reads zero
	localparam logic [15:0] ALARM_MASK = 16'h3DFF;
	localparam logic [15:0] ERR_MASK = 16'h0707;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Bit positions in the alarm change latch and its enable register
	localparam int B_TSRC = 13;
	localparam int B_PT_UNST = 12;
	localparam int B_PT_MISM = 11;
	localparam int B_PT_CHG = 10;
	localparam int B_UA1 = 8;
	localparam int B_GC = 7;
	localparam int B_NR = 6;
	localparam int B_ALIGN = 5;
	localparam int B_LOF = 4;
	localparam int B_RDI = 3;
	localparam int B_AIS = 2;
	localparam int B_OOF = 1;
	localparam int B_LOS = 0;

	// Bit positions in the error latch and its enable register
	localparam int B_REM_EV = 10;
	localparam int B_PAR_EV = 9;
	localparam int B_FRM_EV = 8;
	localparam int B_REM_NZ = 2;
	localparam int B_PAR_NZ = 1;
	localparam int B_FRM_NZ = 0;

	// Maintenance byte field register layout
	localparam int PT_LSB = 4;
	localparam int TSRC_W = 4;

	// Live status bits from the receive framer
	typedef struct packed {
		logic ptype_unstable;
		logic ptype_mismatch;
		logic unframed_all_ones;
		logic frame_loss;
		logic remote_defect;
		logic alarm_ind;
		logic out_of_frame;
		logic signal_loss;
	} live_status_s;

	// One bit per error class: remote, parity, framing
	typedef struct packed {
		logic remote;
		logic parity;
		logic framing;
	} err_trio_s;
endpackage

// file: hw/rx_status_latch_irq.sv
/*
 * Receive status latches, interrupt enables and maintenance byte fields for
 * one E3 G.832 framer port, reached over APB.
 * Assumes the framer delivers live status levels, one-cycle error event
 * pulses, integrated overhead values and error counts in the clock_i domain.
 */
// Behaviour
// RULE1 - Timing source latch bit 13 sets on any change of four timing bits
// RULE2 - Payload unstable latch bit 12 sets only on rising live bit
// RULE3 - Payload mismatch latch bit 11 sets only on rising live bit
// RULE4 - Payload type change latch bit 10 sets when three-bit type changes
// RULE5 - Unframed all-ones latch bit 8 sets on either edge
// RULE6 - General communication byte latch bit 7 sets on byte change
// RULE7 - Network requirement byte latch bit 6 sets on byte change
// RULE8 - Frame alignment latch bit 5 sets when reload alignment differs
// RULE9 - Loss of frame latch bit 4 sets on either edge
// RULE10 - Remote defect latch bit 3 sets on either edge
// RULE11 - Alarm, out-of-frame, signal loss latches bits 2..0 set on any edge
// RULE12 - Remote error event latch bit 10 sets on each remote error
// RULE13 - Parity error event latch bit 9 sets on each BIP-8 error
// RULE14 - Framing error event latch bit 8 sets on each framing error
// RULE15 - Count-nonzero latches bits 2..0 set only on rising nonzero flag
// RULE16 - Interrupt needs latch set, enable one, and port global enable
// RULE17 - Enables reset to zero; one enables
// RULE18 - Alarm enables at 12Ch, same bit as their latch
// RULE19 - Error enables at 12Eh, bits 10..8 and 2..0
// RULE20 - Error latches at 12Ah, bits 11 and 3 reserved
// RULE21 - Read-only 130h: payload type bits 6..4, timing bits 3..0, reset zero
// RULE22 - Count-nonzero flag high when count is one or more
// RULE23 - Payload type field is integrated maintenance byte bits three to five
// RULE24 - With extraction off, timing bit three is zero, low bits from byte tail
// RULE25 - Latches stay set until software writes one; zero leaves them
// RULE26 - All enabled set latches merge into one request, dropping when cleared
`timescale 1ns/1ps
module rx_status_latch_irq
	import rx_latch_pkg::*;
#(
	parameter int ALIGN_W = 8,
	parameter int COUNT_W = 16
)
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Framer side
	input wire live_status_s live_i,
	input wire err_trio_s err_event_i,
	input wire logic [COUNT_W-1:0] remote_err_count_i,
	input wire logic [COUNT_W-1:0] parity_err_count_i,
	input wire logic [COUNT_W-1:0] framing_err_count_i,
	input wire logic frame_align_load_i,
	input wire logic [ALIGN_W-1:0] frame_align_pos_i,
	input wire logic [2:0] ma_ptype_bits_i,
	input wire logic [2:0] ma_tail_bits_i,
	input wire logic [TSRC_W-1:0] ma_tsrc_bits_i,
	input wire logic tsrc_extract_dis_i,
	input wire logic [7:0] rx_gen_comm_byte_i,
	input wire logic [7:0] rx_net_req_byte_i,
	input wire logic port_status_irq_enable_i,
	// Results
	output err_trio_s count_nz_o,
	output logic irq_o
);

	// Elaboration-time refusal of widths the logic cannot serve
	if (ALIGN_W < 1 || COUNT_W < 1)
	begin : g_bad_width
		$error("ALIGN_W and COUNT_W must be at least 1");
	end

	// Rising edge of a level
	function automatic logic rose(input logic prev, input logic cur);
		rose = cur & ~prev;
	endfunction

	// Any change of a level
	function automatic logic flip(input logic prev, input logic cur);
		flip = cur ^ prev;
	endfunction

	logic [15:0] alarm_latch_r;
	logic [15:0] alarm_latch_nxt;
	logic [15:0] err_latch_r;
	logic [15:0] err_latch_nxt;
	logic [15:0] alarm_ie_r;
	logic [15:0] err_ie_r;
	logic [2:0] ptype_r;
	logic [TSRC_W-1:0] tsrc_r;
	logic [2:0] ptype_nxt;
	logic [TSRC_W-1:0] tsrc_nxt;
	logic [7:0] gen_comm_r;
	logic [7:0] net_req_r;
	logic [ALIGN_W-1:0] align_r;
	live_status_s live_r;
	err_trio_s nz_nxt;
	err_trio_s nz_r;
	logic [15:0] alarm_set;
	logic [15:0] err_set;
	logic [15:0] wmask;
	logic [15:0] rdata;
	logic [9:0] idx;
	logic hit;
	logic wr_acc;
	logic [31:0] prdata_r;

	// Word index of the access, and whether it is a write access phase to a mapped word
	assign idx = paddr_i[11:2];
	assign wr_acc = psel_i & penable_i & pwrite_i & hit;

	// Bits written as one within the byte lanes that take part in a write
	assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}} & pwdata_i[15:0];

	// Count-nonzero flags from the error counts
	assign nz_nxt.remote = |remote_err_count_i; // see RULE22
	assign nz_nxt.parity = |parity_err_count_i; // see RULE22
	assign nz_nxt.framing = |framing_err_count_i; // see RULE22

	// Integrated maintenance byte fields
	assign ptype_nxt = ma_ptype_bits_i; // see RULE23
	assign tsrc_nxt = tsrc_extract_dis_i ? {1'b0, ma_tail_bits_i} : ma_tsrc_bits_i; // see RULE24

	// Set terms of the alarm and overhead change latches
	always_comb
	begin
		alarm_set = REG_RESET;
		alarm_set[B_TSRC] = tsrc_nxt != tsrc_r; // see RULE1
		alarm_set[B_PT_UNST] = rose(live_r.ptype_unstable, live_i.ptype_unstable); // see RULE2
		alarm_set[B_PT_MISM] = rose(live_r.ptype_mismatch, live_i.ptype_mismatch); // see RULE3
		alarm_set[B_PT_CHG] = ptype_nxt != ptype_r; // see RULE4
		alarm_set[B_UA1] = flip(live_r.unframed_all_ones, live_i.unframed_all_ones); // see RULE5
		alarm_set[B_GC] = rx_gen_comm_byte_i != gen_comm_r; // see RULE6
		alarm_set[B_NR] = rx_net_req_byte_i != net_req_r; // see RULE7
		alarm_set[B_ALIGN] = frame_align_load_i & (frame_align_pos_i != align_r); // see RULE8
		alarm_set[B_LOF] = flip(live_r.frame_loss, live_i.frame_loss); // see RULE9
		alarm_set[B_RDI] = flip(live_r.remote_defect, live_i.remote_defect); // see RULE10
		alarm_set[B_AIS] = flip(live_r.alarm_ind, live_i.alarm_ind); // see RULE11
		alarm_set[B_OOF] = flip(live_r.out_of_frame, live_i.out_of_frame); // see RULE11
		alarm_set[B_LOS] = flip(live_r.signal_loss, live_i.signal_loss); // see RULE11
	end

	// Set terms of the error event and count-nonzero latches
	always_comb
	begin
		err_set = REG_RESET;
		err_set[B_REM_EV] = err_event_i.remote; // see RULE12
		err_set[B_PAR_EV] = err_event_i.parity; // see RULE13
		err_set[B_FRM_EV] = err_event_i.framing; // see RULE14
		err_set[B_REM_NZ] = rose(nz_r.remote, nz_nxt.remote); // see RULE15
		err_set[B_PAR_NZ] = rose(nz_r.parity, nz_nxt.parity); // see RULE15
		err_set[B_FRM_NZ] = rose(nz_r.framing, nz_nxt.framing); // see RULE15
	end

	// Write-one-to-clear; a new event in the clear cycle wins
	always_comb
	begin
		alarm_latch_nxt = alarm_latch_r;
		err_latch_nxt = err_latch_r;
		if (wr_acc && idx == IDX_ALARM_LATCH)
			alarm_latch_nxt = alarm_latch_r & ~wmask; // see RULE25
		if (wr_acc && idx == IDX_ERR_LATCH)
			err_latch_nxt = err_latch_r & ~wmask; // see RULE25
		alarm_latch_nxt = (alarm_latch_nxt | alarm_set) & ALARM_MASK;
		err_latch_nxt = (err_latch_nxt | err_set) & ERR_MASK; // see RULE20
	end

	// Latch registers
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			alarm_latch_r <= REG_RESET;
			err_latch_r <= REG_RESET;
		end
		else
		begin
			alarm_latch_r <= alarm_latch_nxt;
			err_latch_r <= err_latch_nxt;
		end
	end

	// Previous values for change detection
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			live_r <= '0;
			nz_r <= '0;
			gen_comm_r <= 8'h00;
			net_req_r <= 8'h00;
			align_r <= '0;
		end
		else
		begin
			live_r <= live_i;
			nz_r <= nz_nxt;
			gen_comm_r <= rx_gen_comm_byte_i;
			net_req_r <= rx_net_req_byte_i;
			if (frame_align_load_i)
				align_r <= frame_align_pos_i; // see RULE8
		end
	end

	// Maintenance byte field register, cleared at reset
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ptype_r <= 3'h0; // see RULE21
			tsrc_r <= '0;
		end
		else
		begin
			ptype_r <= ptype_nxt;
			tsrc_r <= tsrc_nxt;
		end
	end

	// Interrupt enable registers, all disabled after reset
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			alarm_ie_r <= REG_RESET; // see RULE17
			err_ie_r <= REG_RESET; // see RULE17
		end
		else
		begin
			if (wr_acc && idx == IDX_ALARM_IE) // see RULE18
			begin
				alarm_ie_r[7:0] <= pstrb_i[0] ? pwdata_i[7:0] & ALARM_MASK[7:0] : alarm_ie_r[7:0];
				alarm_ie_r[15:8] <= pstrb_i[1] ? pwdata_i[15:8] & ALARM_MASK[15:8] : alarm_ie_r[15:8];
			end
			if (wr_acc && idx == IDX_ERR_IE) // see RULE19
			begin
				err_ie_r[7:0] <= pstrb_i[0] ? pwdata_i[7:0] & ERR_MASK[7:0] : err_ie_r[7:0];
				err_ie_r[15:8] <= pstrb_i[1] ? pwdata_i[15:8] & ERR_MASK[15:8] : err_ie_r[15:8];
			end
		end
	end

	// Address decode and read mux
	always_comb
	begin
		hit = 1'b1;
		rdata = REG_RESET;
		if (paddr_i[1:0] != 2'h0)
			hit = 1'b0;
		else if (idx == IDX_ALARM_LATCH)
			rdata = alarm_latch_r;
		else if (idx == IDX_ERR_LATCH)
			rdata = err_latch_r; // see RULE20
		else if (idx == IDX_ALARM_IE)
			rdata = alarm_ie_r;
		else if (idx == IDX_ERR_IE)
			rdata = err_ie_r;
		else if (idx == IDX_MAINT)
			rdata = {9'h000, ptype_r, tsrc_r}; // see RULE21
		else
			hit = 1'b0;
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			prdata_r <= 32'h0000_0000;
		else if (psel_i && !penable_i)
			prdata_r <= {16'h0000, rdata};
	end

	// Zero-wait access phase; unmapped or misaligned gives an error
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;
	assign prdata_o = prdata_r;

	// Registered count-nonzero flags out
	assign count_nz_o = nz_r;

	// Merged port interrupt request
	assign irq_o = port_status_irq_enable_i // see RULE16
		& (|(alarm_latch_r & alarm_ie_r) | |(err_latch_r & err_ie_r)); // see RULE26

endmodule

// file: tb/rx_status_latch_irq_checker.sv
/*
 Port-level assertions for the receive status latch block.
 Bound to the block from the testbench top; sees only its ports.
*/
`timescale 1ns/1ps
module rx_status_latch_irq_checker
	import rx_latch_pkg::*;
#(
	parameter int COUNT_W = 16
)
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic [COUNT_W-1:0] remote_err_count_i,
	input wire logic [COUNT_W-1:0] parity_err_count_i,
	input wire logic [COUNT_W-1:0] framing_err_count_i,
	input wire logic port_status_irq_enable_i,
	input wire err_trio_s count_nz_o,
	input wire logic irq_o
);
	// Access phase and decoded hit on the five mapped words
	wire logic acc = psel_i && penable_i;
	wire logic hit = paddr_i[1:0] == 2'h0 &&
		paddr_i[ADDR_W-1:2] inside {IDX_ALARM_LATCH, IDX_ERR_LATCH, IDX_ALARM_IE, IDX_ERR_IE, IDX_MAINT};

	// One clock domain, one reset
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	a_nz_remote: assert property (count_nz_o.remote == ($past(remote_err_count_i) != 0))
		else $error("Remote nonzero flag wrong");
	a_nz_parity: assert property (count_nz_o.parity == ($past(parity_err_count_i) != 0))
		else $error("Parity nonzero flag wrong");
	a_nz_framing: assert property (count_nz_o.framing == ($past(framing_err_count_i) != 0))
		else $error("Framing nonzero flag wrong");
	a_irq_gate: assert property (!port_status_irq_enable_i |-> !irq_o)
		else $error("Interrupt without port enable");
	a_irq_hold: assert property ((irq_o && !(acc && pwrite_i)) ##1 port_status_irq_enable_i |-> irq_o)
		else $error("Interrupt dropped without a write");
	a_map_err: assert property (acc && !hit |-> pslverr_o)
		else $error("Unmapped access not refused");
	a_map_ok: assert property (acc && hit |-> !pslverr_o)
		else $error("Mapped access refused");
	a_upper_zero: assert property (acc |-> prdata_o[31:16] == 16'h0000)
		else $error("Upper read half not zero");
endmodule

// file: tb/rx_status_latch_irq_tb.sv
/*
 Self-checking bench for the receive status latch block: registers over APB,
 latch set and clear, events, counts and interrupt gating.
 Assumes the package, the block and the checker are compiled first.
*/
`timescale 1ns/1ps
module rx_status_latch_irq_tb
	import rx_latch_pkg::*;
;
	localparam logic [11:0] AL = {IDX_ALARM_LATCH, 2'h0};
	localparam logic [11:0] EL = {IDX_ERR_LATCH, 2'h0};
	localparam logic [11:0] AE = {IDX_ALARM_IE, 2'h0};
	localparam logic [11:0] EE = {IDX_ERR_IE, 2'h0};
	localparam logic [11:0] MT = {IDX_MAINT, 2'h0};
	logic clock_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, dis = 0, aload = 0, pirq = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, irq, e;
	live_status_s live = '0;
	err_trio_s ev = '0, nz;
	logic [15:0] cnt [3] = '{16'h0, 16'h0, 16'h0};
	logic [7:0] apos = 0, gc = 0, nr = 0;
	logic [2:0] ptb = 0, tail = 0;
	logic [3:0] tsrc = 0;
	logic [11:0] ad [5] = '{AL, EL, AE, EE, MT};
	int lpos [8] = '{B_PT_UNST, B_PT_MISM, B_UA1, B_LOF, B_RDI, B_AIS, B_OOF, B_LOS};
	int mismatches = 0, checks_done = 0;

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	rx_status_latch_irq dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .live_i(live), .err_event_i(ev),
		.remote_err_count_i(cnt[0]), .parity_err_count_i(cnt[1]), .framing_err_count_i(cnt[2]),
		.frame_align_load_i(aload), .frame_align_pos_i(apos), .ma_ptype_bits_i(ptb), .ma_tail_bits_i(tail),
		.ma_tsrc_bits_i(tsrc), .tsrc_extract_dis_i(dis), .rx_gen_comm_byte_i(gc), .rx_net_req_byte_i(nr),
		.port_status_irq_enable_i(pirq), .count_nz_o(nz), .irq_o(irq));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One APB transfer, held until pready is seen high, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clock_i);
		pen <= 1;
		@(posedge clock_i);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clock_i);
			n++;
		end
		if (n == 20)
			mismatches++;
		r = prdata;
		e = pslverr;
		psel <= 0;
		pen <= 0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 16'h0000);
		chk(r, exp);
	endtask

	// Let a trigger land, read the latch word, then clear it all
	task automatic lat(input logic [11:0] a, input logic [31:0] exp);
		repeat (3) @(posedge clock_i);
		rd(a, exp);
		apb(1, a, 16'hFFFF);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic [15:0] v;
		v = $urandom(32'h5E5861A8);
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1;
		@(posedge clock_i);
		foreach (ad[i]) rd(ad[i], 0);
		v = $urandom;
		apb(1, AE, v);
		rd(AE, v & ALARM_MASK);
		apb(1, EE, ~v);
		rd(EE, ~v & ERR_MASK);
		apb(1, MT, 16'hFFFF);
		rd(MT, 0);
		rd(12'h4A4, 0);
		chk(e, 1);
		// Each live bit rises then falls; two latch on the rise only
		foreach (lpos[k])
		begin
			live[7-k] <= 1;
			lat(AL, 1 << lpos[k]);
			live[7-k] <= 0;
			lat(AL, k < 2 ? 0 : 1 << lpos[k]);
		end
		// Overhead bytes, payload type and timing source
		gc <= $urandom_range(255, 1);
		lat(AL, 1 << B_GC);
		nr <= $urandom_range(255, 1);
		lat(AL, 1 << B_NR);
		ptb <= $urandom_range(7, 1);
		tsrc <= $urandom_range(15, 1);
		lat(AL, 1 << B_PT_CHG | 1 << B_TSRC);
		rd(MT, {ptb, tsrc});
		tail <= ~tsrc[2:0];
		dis <= 1;
		lat(AL, 1 << B_TSRC);
		rd(MT, {ptb, 1'b0, tail});
		// Same alignment reloaded twice: only the first one differs
		apos <= $urandom_range(255, 1);
		for (int i = 0; i < 2; i++)
		begin
			aload <= 1;
			@(posedge clock_i);
			aload <= 0;
			lat(AL, i ? 0 : 1 << B_ALIGN);
		end
		// Error event pulses, framing first
		for (int i = 0; i < 3; i++)
		begin
			ev[i] <= 1;
			@(posedge clock_i);
			ev[i] <= 0;
			lat(EL, 1 << (B_FRM_EV + i));
		end
		// Counts go nonzero, then back to zero
		foreach (cnt[i]) cnt[i] <= $urandom_range(65535, 1);
		lat(EL, 16'h0007);
		chk(nz, 3'b111);
		foreach (cnt[i]) cnt[i] <= 0;
		lat(EL, 0);
		chk(nz, 3'b000);
		// Interrupt gating, write of zero, clear
		pirq <= 1;
		apb(1, EE, 1 << B_PAR_EV);
		chk(irq, 0);
		ev.parity <= 1;
		@(posedge clock_i);
		ev.parity <= 0;
		repeat (2) @(posedge clock_i);
		chk(irq, 1);
		apb(1, EL, 16'h0000);
		chk(irq, 1);
		pirq <= 0;
		@(posedge clock_i);
		@(posedge clock_i);
		chk(irq, 0);
		pirq <= 1;
		apb(1, EL, 1 << B_PAR_EV);
		chk(irq, 0);
		end_of_test();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#100us;
		mismatches++;
		end_of_test();
	end
endmodule

bind rx_status_latch_irq rx_status_latch_irq_checker #(.COUNT_W(COUNT_W)) chk_u (.clock_i(clock_i),
	.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .remote_err_count_i(remote_err_count_i),
	.parity_err_count_i(parity_err_count_i), .framing_err_count_i(framing_err_count_i),
	.port_status_irq_enable_i(port_status_irq_enable_i), .count_nz_o(count_nz_o), .irq_o(irq_o));
